// ### hdl/mac_stat_pkg.sv
// Package for the MAC error statistics counter bank.
// Assumes a 32-bit APB slave with one aligned word per counter.
package mac_stat_pkg;

	// ======================================================================
	// Register map (byte addresses)
	// ======================================================================
	localparam logic [7:0] ADDR_ALIGN = 8'h00;
	localparam logic [7:0] ADDR_DEFER = 8'h04;
	localparam logic [7:0] ADDR_LATE = 8'h08;
	localparam logic [7:0] ADDR_EXCESS_COLLISION_COUNT = 8'h0c;
	localparam logic [7:0] ADDR_UNDR = 8'h10;
	localparam logic [7:0] ADDR_CSERR = 8'h14;
	localparam logic [7:0] ADDR_RES = 8'h18;
	localparam logic [7:0] ADDR_OVR = 8'h1c;
	localparam logic [7:0] ADDR_SYM = 8'h20;
	localparam logic [7:0] ADDR_LONG = 8'h24;
	localparam logic [7:0] ADDR_CFG = 8'h28;

	// ======================================================================
	// Field layout and reset values
	// ======================================================================
	localparam int CFG_BIG_BIT = 8;
	localparam int W8 = 8;
	localparam int W16 = 16;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;

	// ======================================================================
	// Frame length bounds in bytes
	// ======================================================================
	localparam logic [15:0] LEN_MIN = 16'h0040;
	localparam logic [15:0] LEN_MAX = 16'h05ee;
	localparam logic [15:0] LEN_MAX_BIG = 16'h0600;

endpackage : mac_stat_pkg

// ### hdl/mac_error_statistics_counters.sv
// Error statistics counter bank of an Ethernet MAC with an APB register port.
// Assumes transmit and receive logic deliver one-cycle classified frame
// reports synchronous to i_ref_clk; the slave answers without wait states.
//
// Contract
// - 8-bit alignment counter: 64..max bytes, odd bits, CRC bad.
// - Config bit 8 raises the upper length bound from 1518 to 1536.
// - Symbol error in valid-length odd-bit frame also counts alignment.
// - 16-bit deferred counter for frames deferred at first attempt.
// - Deferred counter skips frames with collisions or underrun.
// - 8-bit late collision counter for collisions after 512 bit times.
// - Late collision also reported as ordinary collision.
// - 8-bit excessive collision counter for frames dropped after 16.
// - 8-bit underrun counter for frames lost to transmit DMA underrun.
// - Underrun frame increments no other counter.
// - 8-bit carrier sense error counter for clean transmitted frames.
// - Carrier sense counter updates only in half duplex.
// - Carrier sense error affects nothing but its own counter.
// - 16-bit resource error counter for matched frames without buffer.
// - 8-bit overrun counter for recognised frames lost to DMA overrun.
// - 8-bit symbol error counter for frames with rx_er asserted.
// - Symbol error frame of valid length also counts FCS or alignment.
// - Oversize symbol error frame also reported as jabber.
// - 8-bit long frame counter: oversize, no CRC/alignment/symbol error.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
module mac_error_statistics_counters #(
	parameter int ADDR_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Transmit frame report, one-cycle pulse at frame end.
	input wire logic i_tx_done,
	input wire logic i_tx_deferred,
	input wire logic i_tx_collided,
	input wire logic i_tx_late_col,
	input wire logic i_tx_excess_col,
	input wire logic i_tx_underrun,
	input wire logic i_tx_crs_lost,
	input wire logic i_full_duplex,
	// Receive frame report, one-cycle pulse at frame end.
	input wire logic i_rx_done,
	input wire logic [15:0] i_rx_len,
	input wire logic i_rx_odd_bits,
	input wire logic i_rx_crc_bad,
	input wire logic i_rx_sym_err,
	input wire logic i_rx_no_buf,
	input wire logic i_rx_overrun,
	// Side reports to neighbouring counters.
	output logic o_collision,
	output logic o_fcs_err,
	output logic o_jabber
);

	// ======================================================================
	// Frame classification
	// ======================================================================
	logic [31:0] cfg_q;
	logic [15:0] max_len;
	logic len_ok, len_long, tx_ok;
	logic inc_align, inc_fcs, inc_jab, inc_defer, inc_late, inc_excess_collision_count;
	logic inc_undr, inc_cse, inc_res, inc_ovr, inc_sym, inc_long;

	// Bounds and per-frame increment decisions.
	always_comb begin
		max_len = cfg_q[mac_stat_pkg::CFG_BIG_BIT] ?
			mac_stat_pkg::LEN_MAX_BIG : mac_stat_pkg::LEN_MAX;
		len_ok = (i_rx_len >= mac_stat_pkg::LEN_MIN) && (i_rx_len <= max_len);
		len_long = i_rx_len > max_len;
		tx_ok = i_tx_done && !i_tx_underrun;
		inc_align = i_rx_done && len_ok && i_rx_odd_bits &&
			(i_rx_crc_bad || i_rx_sym_err);
		inc_fcs = i_rx_done && len_ok && !i_rx_odd_bits &&
			(i_rx_crc_bad || i_rx_sym_err);
		inc_jab = i_rx_done && len_long &&
			(i_rx_crc_bad || i_rx_odd_bits || i_rx_sym_err);
		inc_long = i_rx_done && len_long && !i_rx_crc_bad &&
			!i_rx_odd_bits && !i_rx_sym_err;
		inc_defer = tx_ok && i_tx_deferred && !i_tx_collided &&
			!i_tx_late_col && !i_tx_excess_col;
		inc_late = tx_ok && i_tx_late_col;
		inc_excess_collision_count = tx_ok && i_tx_excess_col;
		inc_undr = i_tx_done && i_tx_underrun;
		// Only its own counter sees the carrier sense error.
		inc_cse = tx_ok && i_tx_crs_lost && !i_full_duplex &&
			!i_tx_collided && !i_tx_late_col;
		inc_res = i_rx_done && i_rx_no_buf;
		inc_ovr = i_rx_done && i_rx_overrun;
		inc_sym = i_rx_done && i_rx_sym_err;
	end

	// ======================================================================
	// Counter bank
	// ======================================================================
	localparam int N = 10;
	logic [N-1:0] inc;
	logic [N-1:0] wsel;
	logic [15:0] cnt_q [N];
	logic [7:0] offs [N];
	int widths [N];
	logic apb_wr;

	assign inc = {inc_long, inc_sym, inc_ovr, inc_res, inc_cse, inc_undr,
		inc_excess_collision_count, inc_late, inc_defer, inc_align};
	assign apb_wr = i_psel && i_penable && i_pwrite;

	// Offset and width of each counter, in bank order.
	always_comb begin
		offs[0] = mac_stat_pkg::ADDR_ALIGN;
		offs[1] = mac_stat_pkg::ADDR_DEFER;
		offs[2] = mac_stat_pkg::ADDR_LATE;
		offs[3] = mac_stat_pkg::ADDR_EXCESS_COLLISION_COUNT;
		offs[4] = mac_stat_pkg::ADDR_UNDR;
		offs[5] = mac_stat_pkg::ADDR_CSERR;
		offs[6] = mac_stat_pkg::ADDR_RES;
		offs[7] = mac_stat_pkg::ADDR_OVR;
		offs[8] = mac_stat_pkg::ADDR_SYM;
		offs[9] = mac_stat_pkg::ADDR_LONG;
		for (int k = 0; k < N; k++) begin
			widths[k] = mac_stat_pkg::W8;
		end
		widths[1] = mac_stat_pkg::W16;
		widths[6] = mac_stat_pkg::W16;
	end

	// Each counter wraps at its own width; a software write wins the cycle.
	for (genvar g = 0; g < N; g++) begin : g_cnt
		logic [15:0] mask;
		assign mask = (widths[g] == mac_stat_pkg::W16) ? 16'hffff : 16'h00ff;
		assign wsel[g] = apb_wr && (i_paddr[7:0] == offs[g]);
		always_ff @(posedge i_ref_clk) begin
			if (i_rst) begin
				cnt_q[g] <= mac_stat_pkg::CNT_RST;
			end else if (i_ce) begin
				if (wsel[g]) begin
					cnt_q[g] <= i_pwdata[15:0] & mask;
				end else if (inc[g]) begin
					cnt_q[g] <= (cnt_q[g] + 16'h0001) & mask;
				end
			end
		end
	end

	// ======================================================================
	// APB slave
	// ======================================================================
	logic hit;
	logic [31:0] rdata;

	// Read mux; unused upper counter bits are zero and unmapped reads give zero.
	always_comb begin
		hit = 1'b0;
		rdata = 32'h0000_0000;
		for (int k = 0; k < N; k++) begin
			if (i_paddr[7:0] == offs[k]) begin
				hit = 1'b1;
				rdata = {16'h0000, cnt_q[k]};
			end
		end
		if (i_paddr[7:0] == mac_stat_pkg::ADDR_CFG) begin
			hit = 1'b1;
			rdata = cfg_q;
		end
	end

	// Configuration register holds the big-frame enable bit.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cfg_q <= mac_stat_pkg::CFG_RST;
		end else if (i_ce && apb_wr &&
			i_paddr[7:0] == mac_stat_pkg::ADDR_CFG) begin
			cfg_q <= i_pwdata;
		end
	end

	// Answer in the first access cycle; pready is a one-cycle pulse.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit;
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rdata : 32'h0;
		end
	end

	// ======================================================================
	// Side reports
	// ======================================================================
	// Collision, FCS and jabber pulses for the neighbouring counters.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_collision <= 1'b0;
			o_fcs_err <= 1'b0;
			o_jabber <= 1'b0;
		end else if (i_ce) begin
			o_collision <= tx_ok && (i_tx_collided || i_tx_late_col);
			o_fcs_err <= inc_fcs;
			o_jabber <= inc_jab;
		end
	end

	// ======================================================================
	// Assertions
	// ======================================================================
	// Each counter is watched from the frame report flags it depends on.

	// A bad-CRC odd-bit frame of valid length steps the alignment count.
	AST_ALIGN_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && inc_align && !wsel[0] |=> cnt_q[0] ==
		(($past(cnt_q[0]) + 16'h0001) & 16'h00ff))
		else $error("alignment counter did not step");

	// With the big-frame bit set a 1536-byte frame is still valid length.
	AST_BIG_LEN: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		cfg_q[mac_stat_pkg::CFG_BIG_BIT] && i_rx_done &&
		i_rx_len == mac_stat_pkg::LEN_MAX_BIG && i_rx_crc_bad &&
		i_rx_odd_bits |-> inc_align)
		else $error("big frame not counted with the bit set");

	// Without the big-frame bit anything past 1518 bytes is oversize.
	AST_STD_LEN: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		!cfg_q[mac_stat_pkg::CFG_BIG_BIT] && i_rx_done &&
		i_rx_len > mac_stat_pkg::LEN_MAX |-> !inc_align && !inc_fcs)
		else $error("oversize frame counted as valid length");

	// A symbol error in an odd-bit valid frame counts as alignment.
	AST_SYM_ALIGN: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_rx_done && len_ok && i_rx_odd_bits && i_rx_sym_err |-> inc_align)
		else $error("symbol error not counted as alignment");

	// A clean deferred frame steps the deferred count.
	AST_DEFER_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_deferred && !i_tx_collided &&
		!i_tx_late_col && !i_tx_excess_col && !i_tx_underrun && !wsel[1]
		|=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
		else $error("deferred counter did not step");

	// Collided or underrun frames never reach the deferred count.
	AST_DEFER_CLEAN: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		inc_defer |-> !i_tx_collided && !i_tx_underrun && !i_tx_late_col)
		else $error("deferred counted on dirty frame");

	// A late collision steps the late collision count.
	AST_LATE_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_late_col && !i_tx_underrun &&
		!wsel[2] |=> cnt_q[2] == (($past(cnt_q[2]) + 16'h0001) & 16'h00ff))
		else $error("late collision counter did not step");

	// A late collision is also reported as an ordinary collision.
	AST_LATE_BOTH: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && inc_late |=> o_collision)
		else $error("late collision not reported as collision");

	// A frame abandoned after 16 collisions steps the excessive count.
	AST_EXCESS_COLLISION_COUNT_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_excess_col && !i_tx_underrun &&
		!wsel[3] |=> cnt_q[3] == (($past(cnt_q[3]) + 16'h0001) & 16'h00ff))
		else $error("excessive collision counter did not step");

	// An underrun frame steps the underrun count.
	AST_UNDR_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_underrun && !wsel[4] |=>
		cnt_q[4] == (($past(cnt_q[4]) + 16'h0001) & 16'h00ff))
		else $error("underrun counter did not step");

	// An underrun frame touches no other transmit counter.
	AST_UNDR_ONLY: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_tx_done && i_tx_underrun |-> !inc_late && !inc_excess_collision_count &&
		!inc_defer && !inc_cse)
		else $error("underrun frame counted elsewhere");

	// An underrun frame raises no collision report either.
	AST_UNDR_NOCOL: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_underrun |=> !o_collision)
		else $error("underrun frame reported as collision");

	// A clean half-duplex frame with carrier trouble steps its count.
	AST_CSE_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_crs_lost && !i_tx_collided &&
		!i_tx_late_col && !i_tx_underrun && !i_full_duplex && !wsel[5]
		|=> cnt_q[5] == (($past(cnt_q[5]) + 16'h0001) & 16'h00ff))
		else $error("carrier sense counter did not step");

	// In full duplex the carrier sense count stands still.
	AST_CSE_HALF: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_full_duplex && !wsel[5] |=> $stable(cnt_q[5]))
		else $error("carrier sense counter moved in full duplex");

	// Carrier trouble does not stop a deferred frame being counted.
	AST_CSE_ALONE: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_tx_done && i_tx_crs_lost && i_tx_deferred &&
		!i_tx_collided && !i_tx_late_col && !i_tx_excess_col &&
		!i_tx_underrun && !wsel[1]
		|=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
		else $error("carrier sense error changed the deferred count");

	// A matched frame without a buffer steps the resource count.
	AST_RES_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && i_rx_no_buf && !wsel[6] |=>
		cnt_q[6] == $past(cnt_q[6]) + 16'h0001)
		else $error("resource counter did not step");

	// A frame lost to receive overrun steps the overrun count.
	AST_OVR_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && i_rx_overrun && !wsel[7] |=>
		cnt_q[7] == (($past(cnt_q[7]) + 16'h0001) & 16'h00ff))
		else $error("overrun counter did not step");

	// A frame with a symbol error steps the symbol count.
	AST_SYM_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && i_rx_sym_err && !wsel[8] |=>
		cnt_q[8] == (($past(cnt_q[8]) + 16'h0001) & 16'h00ff))
		else $error("symbol counter did not step");

	// A symbol error in an integral valid frame is an FCS error too.
	AST_FCS_PULSE: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && len_ok && !i_rx_odd_bits && i_rx_sym_err
		|=> o_fcs_err)
		else $error("symbol error not reported as FCS error");

	// A symbol error in an oversize frame is reported as jabber.
	AST_JAB_PULSE: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && len_long && i_rx_sym_err |=> o_jabber)
		else $error("oversize symbol error not reported as jabber");

	// A clean oversize frame steps the long frame count.
	AST_LONG_INC: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && i_rx_done && len_long && !i_rx_crc_bad && !i_rx_odd_bits &&
		!i_rx_sym_err && !wsel[9]
		|=> cnt_q[9] == (($past(cnt_q[9]) + 16'h0001) & 16'h00ff))
		else $error("long frame counter did not step");

	// A long frame is never also an error frame.
	AST_LONG: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		inc_long |-> !inc_jab && !inc_align && !inc_fcs)
		else $error("long frame double classified");

	// A write loads the counter with the low bits of the write data.
	AST_WRITE: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_ce && wsel[0] |=> cnt_q[0] == {8'h00, $past(i_pwdata[7:0])})
		else $error("write did not load the counter");

	// An 8-bit counter never shows bits above its width.
	AST_UPPER0: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		cnt_q[8][15:8] == 8'h00)
		else $error("8-bit counter upper bits set");

	// Reset clears the alignment and resource counters and the configuration.
	AST_RESET: assert property (
		@(posedge i_ref_clk)
		i_rst |=> cnt_q[6] == 16'h0000 && cnt_q[0] == 16'h0000 &&
		cfg_q == mac_stat_pkg::CFG_RST)
		else $error("counters not cleared by reset");

	// Main scenarios that the bench is expected to reach.
	COV_ALIGN: cover property (@(posedge i_ref_clk) inc_align);
	COV_LATE: cover property (@(posedge i_ref_clk) inc_late);
	COV_JAB: cover property (@(posedge i_ref_clk) inc_jab);
	COV_WRITE: cover property (@(posedge i_ref_clk) apb_wr && o_pready);
	COV_CSE: cover property (@(posedge i_ref_clk) inc_cse);

endmodule : mac_error_statistics_counters

// ### dv/frame_source.sv
// Model of the transmit and receive logic that reports classified frames.
// Assumes the bench commands it just after a rising edge of i_ref_clk.
`timescale 1ns/100ps
module frame_source (
	input wire logic i_ref_clk,
	input wire logic i_tx_go,
	input wire logic [5:0] i_tx_f,
	input wire logic i_rx_go,
	input wire logic [15:0] i_rx_len,
	input wire logic [4:0] i_rx_f,
	output logic o_tx_done,
	output logic [5:0] o_tx_f,
	output logic o_rx_done,
	output logic [15:0] o_rx_len,
	output logic [4:0] o_rx_f
);
	// ======================================================================
	// Report pulses
	// ======================================================================
	// Outside a report the flags toggle so no stale value looks valid.
	initial begin
		{o_tx_done, o_rx_done, o_tx_f, o_rx_f, o_rx_len} = '0;
	end
	always @(posedge i_ref_clk) begin
		o_tx_done <= i_tx_go;
		o_rx_done <= i_rx_go;
		o_tx_f <= i_tx_go ? i_tx_f : ~o_tx_f;
		o_rx_f <= i_rx_go ? i_rx_f : ~o_rx_f;
		o_rx_len <= i_rx_go ? i_rx_len : ~o_rx_len;
	end
endmodule : frame_source

// ### dv/mac_error_statistics_counters_bench.sv
// Self-checking bench for the MAC error statistics counter bank.
// Assumes a zero-wait APB slave and frame reports from frame_source.
`timescale 1ns/100ps
module mac_error_statistics_counters_bench;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, fd = 0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h0, prdata, r, ex[10];
	logic pready, perr, e, col, fcs, jab, tgo = 0, rgo = 0;
	logic td, rd, ce = 1;
	logic [5:0] tf = 6'h00, tfo;
	logic [4:0] rf = 5'h00, rfo;
	logic [15:0] rl = 16'h0000, rlo;
	int n_fail = 0, comparisons = 0;

	// ======================================================================
	// Clock, partner and device
	// ======================================================================
	// The clock runs at 250 MHz.
	always #2 clk = ~clk;
	frame_source src_u (.i_ref_clk(clk), .i_tx_go(tgo), .i_tx_f(tf),
		.i_rx_go(rgo), .i_rx_len(rl), .i_rx_f(rf), .o_tx_done(td),
		.o_tx_f(tfo), .o_rx_done(rd), .o_rx_len(rlo), .o_rx_f(rfo));
	mac_error_statistics_counters dut_u (.i_ref_clk(clk), .i_rst(rst),
		.i_ce(ce), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
		.i_paddr(pa), .i_pwdata(pd), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(perr), .i_tx_done(td), .i_tx_deferred(tfo[5]),
		.i_tx_collided(tfo[4]), .i_tx_late_col(tfo[3]),
		.i_tx_excess_col(tfo[2]), .i_tx_underrun(tfo[1]),
		.i_tx_crs_lost(tfo[0]), .i_full_duplex(fd), .i_rx_done(rd),
		.i_rx_len(rlo), .i_rx_odd_bits(rfo[4]), .i_rx_crc_bad(rfo[3]),
		.i_rx_sym_err(rfo[2]), .i_rx_no_buf(rfo[1]), .i_rx_overrun(rfo[0]),
		.o_collision(col), .o_fcs_err(fcs), .o_jabber(jab));

	// ======================================================================
	// Shared tasks
	// ======================================================================
	// Prints the counts and the verdict, then ends the run.
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	// Compares a seen value with the expected one.
	task chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1; pen <= 0; pw <= w; pa <= a; pd <= d;
		@(posedge clk);
		pen <= 1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 40) begin
			n_fail++;
			final_report();
		end
		r = prdata;
		e = perr;
		psel <= 0; pen <= 0;
		@(posedge clk);
	endtask : apb
	// Reads every counter and compares it at its own width.
	task rd_all;
		for (int i = 0; i < 10; i++) begin
			apb(0, mac_stat_pkg::ADDR_ALIGN + 8'(4 * i), 32'h0);
			chk(r, ex[i] & ((i == 1 || i == 6) ? 32'hffff : 32'hff));
		end
	endtask : rd_all
	// Sends one frame report, checks side pulses and all counters.
	task ev(input logic t, input logic [15:0] n, input logic [5:0] f,
		input logic [9:0] m, input logic [2:0] p);
		logic [2:0] s;
		s = 3'h0;
		if (t) begin
			tgo <= 1; tf <= f;
		end else begin
			rgo <= 1; rl <= n; rf <= f[4:0];
		end
		@(posedge clk);
		tgo <= 0; rgo <= 0;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			s = s | {col, fcs, jab};
		end
		chk({29'h0, s}, {29'h0, p});
		for (int i = 0; i < 10; i++) if (m[i]) ex[i] = ex[i] + 1;
		rd_all();
	endtask : ev

	// ======================================================================
	// Scenarios
	// ======================================================================
	// Counters read zero after reset; an unmapped address is refused.
	task t_reset;
		for (int i = 0; i < 10; i++) ex[i] = 32'h0;
		rd_all();
		apb(0, 8'h2c, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		$display("reset test done");
	endtask : t_reset
	// Writes load each counter at its width; then one increment wraps.
	task t_regs;
		for (int i = 0; i < 10; i++) begin
			apb(1, mac_stat_pkg::ADDR_ALIGN + 8'(4 * i), 32'hffff_ffff);
			ex[i] = 32'hffff_ffff;
		end
		ev(0, 16'd64, 5'h18, 10'h001, 3'h0);
		$display("register test done");
	endtask : t_regs
	// Receive classification at the length bounds and with symbol errors.
	task t_rx;
		ev(0, 16'd1518, 5'h18, 10'h001, 3'h0);
		ev(0, 16'd63, 5'h18, 10'h000, 3'h0);
		ev(0, 16'd1519, 5'h18, 10'h000, 3'h1);
		ev(0, 16'd100, 5'h14, 10'h101, 3'h0);
		ev(0, 16'd100, 5'h04, 10'h100, 3'h2);
		ev(0, 16'd1600, 5'h04, 10'h100, 3'h1);
		ev(0, 16'd1519, 5'h00, 10'h200, 3'h0);
		apb(1, mac_stat_pkg::ADDR_CFG, 32'h0000_0100);
		ev(0, 16'd1536, 5'h18, 10'h001, 3'h0);
		ev(0, 16'd1536, 5'h00, 10'h000, 3'h0);
		ev(0, 16'd1537, 5'h00, 10'h200, 3'h0);
		apb(1, mac_stat_pkg::ADDR_CFG, 32'h0);
		ev(0, 16'd100, 5'h02, 10'h040, 3'h0);
		ev(0, 16'd100, 5'h01, 10'h080, 3'h0);
		$display("receive test done");
	endtask : t_rx
	// Transmit classification, exclusions and duplex gating.
	task t_tx;
		ev(1, 16'd0, 6'h20, 10'h002, 3'h0);
		ev(1, 16'd0, 6'h30, 10'h000, 3'h4);
		ev(1, 16'd0, 6'h18, 10'h004, 3'h4);
		ev(1, 16'd0, 6'h14, 10'h008, 3'h4);
		ev(1, 16'd0, 6'h3b, 10'h010, 3'h0);
		ev(1, 16'd0, 6'h01, 10'h020, 3'h0);
		ev(1, 16'd0, 6'h11, 10'h000, 3'h4);
		fd <= 1;
		ev(1, 16'd0, 6'h01, 10'h000, 3'h0);
		fd <= 0;
		ev(1, 16'd0, 6'h21, 10'h022, 3'h0);
		$display("transmit test done");
	endtask : t_tx
	// With the clock enable low a frame report is lost and nothing moves.
	task t_ce;
		logic s;
		s = 1'b0;
		ce <= 0; rgo <= 1; rl <= 16'd100; rf <= 5'h04;
		@(posedge clk);
		rgo <= 0;
		repeat (4) begin
			@(posedge clk);
			s = s | fcs;
		end
		ce <= 1;
		@(posedge clk);
		chk({31'h0, s}, 32'h0);
		rd_all();
		$display("clock enable test done");
	endtask : t_ce

	// Main sequence: reset for 16 cycles, then every scenario.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_reset();
		t_regs();
		t_rx();
		t_tx();
		t_ce();
		final_report();
	end
endmodule : mac_error_statistics_counters_bench
